// >>> rtl/drive_io_pkg.sv
// shared constants, field layouts and carrier types of the drive input and encoder block
package drive_io_pkg;

  // ==========================================================================
  // timing
  localparam int CLK_PERIOD_NS      = 4;
  localparam int ENC_MAX_FREQ_HZ    = 10000;
  localparam int QUAD_MIN_PERIOD_NS = 1000000000 / ENC_MAX_FREQ_HZ;
  // least time per quarter step, rounded up to whole cycles
  localparam int QUARTER_CYCLES     = (QUAD_MIN_PERIOD_NS + 4 * CLK_PERIOD_NS - 1)
                                      / (4 * CLK_PERIOD_NS);

  // ==========================================================================
  // sizes
  localparam int NUM_DI    = 7;
  localparam int NUM_WORDS = 4;
  localparam int WORD_W    = 16;
  localparam int PEND_W    = 8;
  localparam int TIMER_W   = 16;

  // ==========================================================================
  // register byte offsets
  localparam logic [11:0] ADDR_WORD_ONE   = 12'h000;
  localparam logic [11:0] ADDR_WORD_TWO   = 12'h004;
  localparam logic [11:0] ADDR_WORD_THREE = 12'h008;
  localparam logic [11:0] ADDR_WORD_FOUR  = 12'h00c;
  localparam logic [11:0] ADDR_MAP_BASE   = 12'h010;
  localparam logic [11:0] ADDR_PULSE_SET  = 12'h02c;
  localparam logic [11:0] ADDR_POSITION   = 12'h030;
  localparam logic [11:0] ADDR_RISE_CAP   = 12'h034;
  localparam logic [11:0] ADDR_FALL_CAP   = 12'h038;
  localparam logic [11:0] ADDR_STATUS     = 12'h03c;

  // ==========================================================================
  // input map register fields and reset values
  localparam int MAP_BIT_LSB  = 0;
  localparam int MAP_WORD_LSB = 4;
  localparam int MAP_EN_BIT   = 6;
  localparam logic [6:0]  MAP_RESET       = 7'h00;
  localparam logic [15:0] PULSE_SET_RESET = 16'h0000;

  // ==========================================================================
  // bit positions inside the input words
  localparam int W1_INTERLOCK   = 15;
  localparam int W1_RUN0        = 13;
  localparam int W1_BRAKE_TEST  = 11;
  localparam int W1_JOG_F       = 9;
  localparam int W1_JOG_R       = 8;
  localparam int W1_BRAKE_REL   = 5;
  localparam int W1_FIELD       = 4;
  localparam int W1_BRAKE_HOLD  = 3;
  localparam int W1_FRESET      = 1;
  localparam int W2_BREAKER     = 9;
  localparam int W2_EMERG       = 6;
  localparam int W2_SPEED_HOLD  = 5;
  localparam int W2_FWD_LIMIT   = 3;
  localparam int W2_REV_LIMIT   = 2;
  localparam int W2_BRAKE_FB    = 0;
  localparam int W3_RUN0        = 13;
  localparam int W3_JOG_F       = 9;
  localparam int W3_JOG_R       = 8;
  localparam int W3_FIELD       = 4;
  localparam int W3_CAPTURE     = 3;
  localparam int W3_FRESET      = 1;
  localparam int W4_CUR_LIMIT   = 11;
  localparam int W4_TRQ_LIMIT   = 10;
  localparam int W4_DIR0        = 6;
  localparam int W4_DIR1        = 5;
  localparam int W4_RUN1        = 0;

  // ==========================================================================
  // types
  typedef struct packed {
    logic       en;
    logic [1:0] word;
    logic [3:0] bit_sel;
  } di_map_s;

  typedef struct packed {
    logic run;
    logic interlocked;
    logic jog_fwd;
    logic jog_rev;
    logic reverse;
    logic brake_open;
    logic brake_is_open;
    logic brake_release_issued;
    logic breaker_closed;
    logic fault_reset;
    logic alt_current_limit;
    logic alt_torque_limit;
    logic emergency;
    logic field_on;
    logic fwd_limit_zero;
    logic rev_limit_zero;
    logic speed_hold;
  } drive_ctrl_s;

  typedef enum logic [1:0] {
    JOG_IDLE = 2'b00,
    JOG_FWD  = 2'b01,
    JOG_REV  = 2'b10
  } jog_e;

endpackage : drive_io_pkg

// >>> rtl/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // pins and synchronised copy
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } sync_s;

  sync_s st_reg;
  sync_s st_next;

  // ==========================================================================
  // first stage feeds only the second
  always_comb begin
    st_next        = st_reg;
    st_next.meta   = d;
    st_next.stable = st_reg.meta;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.stable;

endmodule : pin_sync

// >>> rtl/quad_repeater.sv
// rate-limited two-phase pulse repeater for encoder pulses
`timescale 1ns/1ns
module quad_repeater import drive_io_pkg::*; #(
  parameter int QUARTER = QUARTER_CYCLES
) (
  // clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // pulse request
  input  wire logic pulse_in,
  input  wire logic reverse,
  input  wire logic enable,
  // phase outputs
  output logic      quad_a,
  output logic      quad_b
);

  typedef struct packed {
    logic [PEND_W-1:0]  pend;
    logic [1:0]         steps;
    logic               stepping;
    logic [1:0]         phase;
    logic [TIMER_W-1:0] timer;
    logic               qa;
    logic               qb;
  } quad_s;

  quad_s st_reg;
  quad_s st_next;
  logic  take;
  logic  step;

  // ==========================================================================
  // pulse queue and quarter stepping
  always_comb begin
    st_next = st_reg;
    take    = pulse_in && enable && (st_reg.pend != {PEND_W{1'b1}}); // R2
    step    = (st_reg.timer == '0) && (st_reg.stepping || (st_reg.pend != '0));
    if (st_reg.timer != '0) begin
      st_next.timer = st_reg.timer - 1'b1;
    end
    if (step) begin
      // each pulse becomes four quarter steps, each held at least a quarter of 100 us
      st_next.timer = TIMER_W'(QUARTER - 1); // R3
      st_next.phase = reverse ? st_reg.phase - 2'd1 : st_reg.phase + 2'd1; // R4
      st_next.qa    = st_next.phase[1];
      st_next.qb    = st_next.phase[1] ^ st_next.phase[0];
      if (!st_reg.stepping) begin
        st_next.stepping = 1'b1;
        st_next.steps    = 2'd3;
      end else begin
        st_next.steps    = st_reg.steps - 2'd1;
        st_next.stepping = (st_reg.steps != 2'd1);
      end
    end
    st_next.pend = st_reg.pend + PEND_W'(take) - PEND_W'(step && !st_reg.stepping);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign quad_a = st_reg.qa;
  assign quad_b = st_reg.qb;

  // ==========================================================================
  // checks
  logic [TIMER_W-1:0] gap_cnt;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_cnt <= '0;
    end else if ((st_next.qa != st_reg.qa) || (st_next.qb != st_reg.qb)) begin
      gap_cnt <= '0;
    end else if (gap_cnt != {TIMER_W{1'b1}}) begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

  quarter_spacing_a : assert property ( // R3
    @(posedge pclk) disable iff (!presetn)
    ($changed(quad_a) || $changed(quad_b)) |-> ($past(gap_cnt) >= TIMER_W'(QUARTER - 1)))
    else $error("phase changed before a quarter period elapsed");

  one_phase_a : assert property ( // R4
    @(posedge pclk) disable iff (!presetn)
    !($changed(quad_a) && $changed(quad_b)))
    else $error("both phases changed in the same cycle");

  pulse_queued_a : assert property ( // R2
    @(posedge pclk) disable iff (!presetn)
    (pulse_in && enable && st_reg.pend == '0) |=> (st_reg.pend == 8'h01))
    else $error("encoder pulse not queued for repeat");

endmodule : quad_repeater

// >>> rtl/drive_input_word_and_encoder_io.sv
// discrete input words, control decode, encoder position capture and pulse repeat
`timescale 1ns/1ns
// Operation
// [R1] accept one single-ended encoder channel, counting correctly up to 10 kHz
// [R2] with pulse-count setting zero, one output pulse per encoder pulse
// [R3] repeated pulse output never exceeds 10 kHz
// [R4] output is two phases a quarter period apart, order shows direction
// [R5] seven discrete inputs, each assignable to any bit of four words
// [R6] brake release issued bit: 1 sent elsewhere, 0 not sent
// [R7] brake feedback bit: 1 brake open, 0 brake closed
// [R8] brake hold request 0 forces brake closed, 1 normal sequencing
// [R9] brake test request 1 forces brake open, 0 normal
// [R10] breaker state 1 closed, 0 open
// [R11] direction bits 0 forward, 1 reverse, honoured only in remote mode
// [R12] fault reset on ext fault reset; source must pulse it momentarily
// [R13] two-wire run inputs are levels: run while 1, stop while 0
// [R14] current limit select 0 normal, 1 alternate limit
// [R15] torque limit select 0 normal pair, 1 alternate pair
// [R16] emergency run 1 emergency operation, 0 normal
// [R17] jog pair: single starts that way, both first wins, none stops; run off
// [R18] field enable 1 field on when ready, 0 off until start
// [R19] speed limit bits 1 apply limit, 0 force that direction to zero
// [R20] speed hold 1 freezes speed reference, 0 follows
// [R21] safety interlock 1 allows operation, 0 holds drive interlocked
// [R22] capture position on capture input rising and falling edges
// [R23] synchronise inputs before word update, decode and edge detection
module drive_input_word_and_encoder_io import drive_io_pkg::*; #(
  parameter int QUARTER_CYCLES_P = QUARTER_CYCLES
) (
  // apb slave
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // field pins
  input  wire logic [NUM_DI-1:0] di_pin,
  input  wire logic              enc_pin,
  input  wire logic              keypad_remote,
  // pulse repeat
  output logic                   quad_out_a,
  output logic                   quad_out_b,
  // decoded controls
  output drive_ctrl_s            ctrl
);

  typedef struct packed {
    di_map_s [NUM_DI-1:0]                 map;
    logic [15:0]                          pulse_set;
    logic [NUM_WORDS-1:0][WORD_W-1:0]     words;
    logic [31:0]                          position;
    logic [31:0]                          rise_cap;
    logic [31:0]                          fall_cap;
    jog_e                                 jog;
    logic                                 jog_f_q;
    logic                                 jog_r_q;
    logic                                 cap_q;
    logic                                 freset_q;
    logic                                 enc_q;
    drive_ctrl_s                          ctrl;
    logic [31:0]                          rdata;
  } io_s;

  io_s                 st_reg;
  io_s                 st_next;
  logic [NUM_DI:0]     pins_s;
  logic [NUM_DI-1:0]   di_s;
  logic                enc_s;
  logic                enc_edge;
  logic                wr_en;
  logic                rd_setup;
  logic                unmapped;
  logic [31:0]         rd_val;
  logic                run0;
  logic                run_any;
  logic                jog_f;
  logic                jog_r;
  logic                field_bit;
  logic                freset_bit;
  logic                cap_bit;
  logic                interlock_ok;
  logic                run_now;
  logic                jog_now;

  // ==========================================================================
  // pin synchronisers
  pin_sync #(.W(NUM_DI + 1)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({enc_pin, di_pin}),
    .q       (pins_s)
  );

  assign di_s     = pins_s[NUM_DI-1:0]; // R23
  assign enc_s    = pins_s[NUM_DI];
  assign enc_edge = enc_s && !st_reg.enc_q; // R1

  // ==========================================================================
  // pulse repeater
  quad_repeater #(.QUARTER(QUARTER_CYCLES_P)) u_quad (
    .pclk     (pclk),
    .presetn  (presetn),
    .pulse_in (enc_edge),
    .reverse  (st_reg.ctrl.reverse),
    .enable   (st_reg.pulse_set == 16'h0000), // R2
    .quad_a   (quad_out_a),
    .quad_b   (quad_out_b)
  );

  // ==========================================================================
  // apb decode
  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable && !pwrite;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && unmapped;
  assign prdata   = st_reg.rdata;

  always_comb begin
    rd_val   = 32'h0000_0000;
    unmapped = 1'b0;
    case (paddr)
      ADDR_WORD_ONE:   rd_val = {16'h0000, st_reg.words[0]};
      ADDR_WORD_TWO:   rd_val = {16'h0000, st_reg.words[1]};
      ADDR_WORD_THREE: rd_val = {16'h0000, st_reg.words[2]};
      ADDR_WORD_FOUR:  rd_val = {16'h0000, st_reg.words[3]};
      ADDR_PULSE_SET:  rd_val = {16'h0000, st_reg.pulse_set};
      ADDR_POSITION:   rd_val = st_reg.position;
      ADDR_RISE_CAP:   rd_val = st_reg.rise_cap;
      ADDR_FALL_CAP:   rd_val = st_reg.fall_cap;
      ADDR_STATUS:     rd_val = {15'h0000, st_reg.ctrl};
      default: begin
        unmapped = 1'b1;
        for (int i = 0; i < NUM_DI; i++) begin
          if (paddr == ADDR_MAP_BASE + 12'(4 * i)) begin
            rd_val   = {25'h0000000, st_reg.map[i]};
            unmapped = 1'b0;
          end
        end
      end
    endcase
  end

  // ==========================================================================
  // field decode from the registered words
  // duplicated functions in two words are ored, so either assignment works
  always_comb begin
    run0         = st_reg.words[0][W1_RUN0] | st_reg.words[2][W3_RUN0];
    run_any      = run0 | st_reg.words[3][W4_RUN1]; // R13
    jog_f        = st_reg.words[0][W1_JOG_F] | st_reg.words[2][W3_JOG_F];
    jog_r        = st_reg.words[0][W1_JOG_R] | st_reg.words[2][W3_JOG_R];
    field_bit    = st_reg.words[0][W1_FIELD] | st_reg.words[2][W3_FIELD];
    freset_bit   = st_reg.words[0][W1_FRESET] | st_reg.words[2][W3_FRESET];
    cap_bit      = st_reg.words[2][W3_CAPTURE];
    interlock_ok = st_reg.words[0][W1_INTERLOCK]; // R21
    run_now      = run_any && interlock_ok;
    jog_now      = (st_reg.jog != JOG_IDLE) && interlock_ok;
  end

  // ==========================================================================
  // next state
  always_comb begin
    st_next = st_reg;

    // unmapped word bits read zero, so safety bits default to the safe side
    st_next.words = '0;
    for (int i = 0; i < NUM_DI; i++) begin
      if (st_reg.map[i].en) begin
        st_next.words[st_reg.map[i].word][st_reg.map[i].bit_sel] = di_s[i]; // R5
      end
    end

    // register writes
    if (wr_en) begin
      if (paddr == ADDR_PULSE_SET) begin
        st_next.pulse_set = pwdata[15:0];
      end
      for (int i = 0; i < NUM_DI; i++) begin
        if (paddr == ADDR_MAP_BASE + 12'(4 * i)) begin
          st_next.map[i] = pwdata[MAP_EN_BIT:MAP_BIT_LSB];
        end
      end
    end
    if (rd_setup) begin
      st_next.rdata = rd_val;
    end

    // encoder position and capture
    st_next.enc_q = enc_s;
    if (enc_edge) begin
      st_next.position = st_reg.ctrl.reverse ? st_reg.position - 32'h1
                                             : st_reg.position + 32'h1; // R1
    end
    st_next.cap_q = cap_bit;
    if (cap_bit && !st_reg.cap_q) begin
      st_next.rise_cap = st_reg.position; // R22
    end
    if (!cap_bit && st_reg.cap_q) begin
      st_next.fall_cap = st_reg.position; // R22
    end

    // jog sequencing
    st_next.jog_f_q = jog_f;
    st_next.jog_r_q = jog_r;
    if (run_any) begin
      st_next.jog = JOG_IDLE; // R17
    end else begin
      case (st_reg.jog)
        JOG_IDLE: begin
          if (jog_f && !jog_r) begin
            st_next.jog = JOG_FWD;
          end else if (jog_r && !jog_f) begin
            st_next.jog = JOG_REV;
          end else if (jog_f && jog_r) begin
            // both present: the one already held wins, forward on a tie
            st_next.jog = (st_reg.jog_r_q && !st_reg.jog_f_q) ? JOG_REV : JOG_FWD; // R17
          end
        end
        JOG_FWD: begin
          if (!jog_f && !jog_r) begin
            st_next.jog = JOG_IDLE;
          end else if (!jog_f) begin
            st_next.jog = JOG_REV;
          end
        end
        JOG_REV: begin
          if (!jog_f && !jog_r) begin
            st_next.jog = JOG_IDLE;
          end else if (!jog_r) begin
            st_next.jog = JOG_FWD;
          end
        end
        default: st_next.jog = JOG_IDLE;
      endcase
    end

    // decoded controls
    st_next.freset_q                  = freset_bit;
    st_next.ctrl.fault_reset          = freset_bit && !st_reg.freset_q; // R12
    st_next.ctrl.interlocked          = !interlock_ok; // R21
    st_next.ctrl.run                  = run_now; // R13
    st_next.ctrl.jog_fwd              = (st_reg.jog == JOG_FWD) && interlock_ok; // R17
    st_next.ctrl.jog_rev              = (st_reg.jog == JOG_REV) && interlock_ok; // R17
    if (keypad_remote) begin
      st_next.ctrl.reverse = st_reg.words[3][W4_DIR0] | st_reg.words[3][W4_DIR1]; // R11
    end
    st_next.ctrl.brake_release_issued = st_reg.words[0][W1_BRAKE_REL]; // R6
    st_next.ctrl.brake_is_open        = st_reg.words[1][W2_BRAKE_FB]; // R7
    // forced closed outranks the test request for safety
    if (!st_reg.words[0][W1_BRAKE_HOLD]) begin
      st_next.ctrl.brake_open = 1'b0; // R8
    end else if (st_reg.words[0][W1_BRAKE_TEST]) begin
      st_next.ctrl.brake_open = 1'b1; // R9
    end else begin
      st_next.ctrl.brake_open = run_now || jog_now
                                || st_reg.words[0][W1_BRAKE_REL];
    end
    st_next.ctrl.breaker_closed       = st_reg.words[1][W2_BREAKER]; // R10
    st_next.ctrl.alt_current_limit    = st_reg.words[3][W4_CUR_LIMIT]; // R14
    st_next.ctrl.alt_torque_limit     = st_reg.words[3][W4_TRQ_LIMIT]; // R15
    st_next.ctrl.emergency            = st_reg.words[1][W2_EMERG]; // R16
    st_next.ctrl.field_on             = field_bit || run_now || jog_now; // R18
    st_next.ctrl.fwd_limit_zero       = !st_reg.words[1][W2_FWD_LIMIT]; // R19
    st_next.ctrl.rev_limit_zero       = !st_reg.words[1][W2_REV_LIMIT]; // R19
    st_next.ctrl.speed_hold           = st_reg.words[1][W2_SPEED_HOLD]; // R20
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign ctrl = st_reg.ctrl;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  brake_forced_closed_a : assert property ( // R8
    !st_reg.words[0][W1_BRAKE_HOLD] |=> !ctrl.brake_open)
    else $error("brake open while hold request low");

  brake_test_open_a : assert property ( // R9
    (st_reg.words[0][W1_BRAKE_HOLD] && st_reg.words[0][W1_BRAKE_TEST]) |=> ctrl.brake_open)
    else $error("brake test did not open brake");

  interlock_stops_run_a : assert property ( // R21
    !st_reg.words[0][W1_INTERLOCK] |=> (!ctrl.run && !ctrl.jog_fwd && !ctrl.jog_rev
                                        && ctrl.interlocked))
    else $error("drive operating while interlocked");

  reset_pulse_once_a : assert property ( // R12
    ctrl.fault_reset |=> !ctrl.fault_reset)
    else $error("fault reset longer than one cycle");

  rise_capture_a : assert property ( // R22
    (cap_bit && !st_reg.cap_q) |=> (st_reg.rise_cap == $past(st_reg.position)))
    else $error("rise capture missed position");

  fall_capture_a : assert property ( // R22
    (!cap_bit && st_reg.cap_q) |=> (st_reg.fall_cap == $past(st_reg.position)))
    else $error("fall capture missed position");

  jog_needs_stop_a : assert property ( // R17
    run_any |=> ##1 (!ctrl.jog_fwd && !ctrl.jog_rev))
    else $error("jog active with run input on");

  direction_local_a : assert property ( // R11
    !keypad_remote |=> $stable(ctrl.reverse))
    else $error("direction changed outside remote mode");

  encoder_count_a : assert property ( // R1
    (enc_edge && !st_reg.ctrl.reverse) |=> (st_reg.position == $past(st_reg.position) + 32'h1))
    else $error("encoder edge not counted");

  limit_zero_a : assert property ( // R19
    !st_reg.words[1][W2_FWD_LIMIT] |=> ctrl.fwd_limit_zero)
    else $error("forward limit not forced to zero");

endmodule : drive_input_word_and_encoder_io

// >>> test/field_model.sv
// field side model: contact levels and single-ended encoder pulses
`timescale 1ns/1ns
// ============================================================================
// field model
module field_model #(
  parameter int SPACE = 20
) (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // requests from the bench
  input  wire logic [6:0] contacts,
  input  wire logic       enc_req,
  // field pins
  output logic      [6:0] di_pin,
  output logic            enc_pin,
  output logic            enc_busy
);
  int cnt;
  assign di_pin   = contacts;
  assign enc_busy = cnt != 0;
  // one channel only, high then low; spacing keeps pulses well apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 0;
      enc_pin <= 1'b0;
    end else if (cnt != 0) begin
      cnt     <= cnt - 1;
      enc_pin <= cnt > SPACE;
    end else if (enc_req) begin
      cnt     <= 2 * SPACE;
      enc_pin <= 1'b1;
    end
  end
endmodule : field_model

// >>> test/testbench.sv
// self-checking bench for the drive input word and encoder block
`timescale 1ns/1ns
// ============================================================================
// bench
module testbench import drive_io_pkg::*;;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        enc_pin, keypad_remote, quad_out_a, quad_out_b, enc_req, enc_busy, prev_a;
  logic        exp_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, p0;
  logic [6:0]  di_pin, contacts;
  drive_ctrl_s ctrl;
  int          err_total, samples_checked, cycles, rises;

  drive_input_word_and_encoder_io #(.QUARTER_CYCLES_P(4)) drive_input_word_and_encoder_io_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .di_pin(di_pin), .enc_pin(enc_pin), .keypad_remote(keypad_remote),
    .quad_out_a(quad_out_a), .quad_out_b(quad_out_b), .ctrl(ctrl));
  field_model field_model_i (.pclk(pclk), .presetn(presetn), .contacts(contacts),
    .enc_req(enc_req), .di_pin(di_pin), .enc_pin(enc_pin), .enc_busy(enc_busy));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic print_verdict();
    if (err_total == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // apb transfer; waits on pready, the bench timeout cuts a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    rd[31] = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic t_regs();
    apb(0, ADDR_MAP_BASE, 0, rd);
    chk(rd, 32'h0000_0000);
    apb(1, ADDR_PULSE_SET, 32'h0000_0003, rd);
    apb(0, ADDR_PULSE_SET, 0, rd);
    chk(rd, 32'h0000_0003);
    apb(1, ADDR_PULSE_SET, 32'h0000_0000, rd);
    apb(1, ADDR_WORD_ONE, 32'h0000_ffff, rd);
    apb(0, ADDR_WORD_ONE, 0, rd);
    chk(rd, 32'h0000_0000);
    apb(0, 12'h100, 0, p0);
    chk({31'h0, rd[31]}, 32'h0000_0001);
  endtask : t_regs

  task automatic t_inputs();
    logic [31:0] maps [7];
    maps = '{32'h4f, 32'h4d, 32'h50, 32'h76, 32'h63, 32'h59, 32'h56};
    foreach (maps[i]) apb(1, ADDR_MAP_BASE + 12'(4 * i), maps[i], rd);
    contacts <= 7'h6f;
    repeat (8) @(posedge pclk);
    apb(0, ADDR_WORD_ONE, 0, rd);
    chk(rd, 32'h0000_a000);
    apb(0, ADDR_WORD_TWO, 0, rd);
    chk(rd, 32'h0000_0241);
    apb(0, ADDR_WORD_FOUR, 0, rd);
    chk(rd, 32'h0000_0040);
    chk({ctrl.run, ctrl.interlocked, ctrl.brake_is_open}, 32'h5);
    chk({ctrl.breaker_closed, ctrl.emergency, ctrl.reverse}, 32'h7);
    contacts <= 7'h00;
    repeat (8) @(posedge pclk);
    chk({ctrl.run, ctrl.interlocked, ctrl.brake_is_open}, 32'h2);
    chk({ctrl.breaker_closed, ctrl.emergency, ctrl.reverse}, 32'h0);
  endtask : t_inputs

  task automatic t_encoder();
    apb(0, ADDR_POSITION, 0, p0);
    rises = 0;
    repeat (3) begin
      @(posedge pclk);
      enc_req <= 1'b1;
      @(posedge pclk);
      enc_req <= 1'b0;
      // busy shows only after the model has taken the request
      @(posedge pclk);
      while (enc_busy) @(posedge pclk);
    end
    contacts <= 7'h10;
    repeat (60) @(posedge pclk);
    apb(0, ADDR_POSITION, 0, rd);
    chk(rd, p0 + 3);
    chk(rises, 3);
    apb(0, ADDR_RISE_CAP, 0, rd);
    chk(rd, p0 + 3);
    enc_req <= 1'b1;
    @(posedge pclk);
    enc_req <= 1'b0;
    repeat (50) @(posedge pclk);
    contacts <= 7'h00;
    repeat (8) @(posedge pclk);
    apb(0, ADDR_FALL_CAP, 0, rd);
    chk(rd, p0 + 4);
  endtask : t_encoder

  task automatic t_reverse();
    contacts <= 7'h08;
    repeat (8) @(posedge pclk);
    exp_b   <= 1'b0;
    enc_req <= 1'b1;
    @(posedge pclk);
    enc_req <= 1'b0;
    repeat (60) @(posedge pclk);
    apb(0, ADDR_POSITION, 0, rd);
    chk(rd, p0 + 3);
    chk(rises, 5);
    keypad_remote <= 1'b0;
    contacts      <= 7'h00;
    repeat (8) @(posedge pclk);
    chk({31'h0, ctrl.reverse}, 32'h1);
    keypad_remote <= 1'b1;
    repeat (8) @(posedge pclk);
    chk({31'h0, ctrl.reverse}, 32'h0);
  endtask : t_reverse

  // forward: b leads, so b is high when a rises; reverse: b is low then
  always @(posedge pclk) begin
    prev_a <= quad_out_a;
    cycles <= cycles + 1;
    if (quad_out_a === 1'b1 && prev_a === 1'b0) begin
      rises <= rises + 1;
      chk({31'h0, quad_out_b}, {31'h0, exp_b});
    end
    if (cycles == 20000) begin
      err_total++;
      print_verdict();
    end
  end

  initial begin
    {psel, penable, pwrite, enc_req, prev_a, keypad_remote} = 6'b000001;
    exp_b = 1'b1;
    paddr = 12'h000;
    pwdata = 32'h0;
    contacts = 7'h00;
    {err_total, samples_checked, cycles} = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_inputs();
    t_encoder();
    t_reverse();
    print_verdict();
  end
endmodule : testbench
